//--- pkg/fst_defines.vh
// Constants for the frame start trigger and exposure controller.
// Assumes a 25 MHz reference clock; all times are counted in 1 us ticks.
//
// Overview of operation
// - Enabled hardware source selects frame start trigger.
// - Edge select picks rising or falling trigger.
// - Selected edge starts exposure, leaves waiting state.
// - Waiting state returns automatically when ready again.
// - One frame acquired per accepted trigger.
// - Edges outside waiting state are discarded.
// - Trigger during exposure ignored, overtrigger flagged.
// - Timed mode exposes for programmed microsecond count.
// - Width mode exposes until opposite edge.
// - Only timed and trigger width modes exist.
// - Width mode uses overlap limit for waiting status.
// - Start delay of 0 to 1000000 us.
// - Zero delay adds no delay.
// - Delay length taken from raw delay count.
// - No delay when triggering off or software.
// - Exposure raw value counts one microsecond units.
// - Waiting status reads one when trigger acceptable.
`ifndef FST_DEFINES_VH
`define FST_DEFINES_VH
`define FST_CLK_HZ        25000000
`define FST_TICK_NS       1000
`define FST_CLK_NS        40
`define FST_TICK_CYCLES   (`FST_TICK_NS / `FST_CLK_NS)
`define FST_SRC_LINE1     3'h0
`define FST_SRC_CC1       3'h1
`define FST_SRC_CC2       3'h2
`define FST_SRC_CC3       3'h3
`define FST_SRC_SOFTWARE  3'h4
`define FST_MODE_TIMED    1'b0
`define FST_MODE_WIDTH    1'b1
`define FST_EDGE_RISING   1'b0
`define FST_EDGE_FALLING  1'b1
`define FST_DELAY_MAX     20'hf4240
`define FST_TIME_W        22
`define FST_DELAY_W       20
`endif

//--- logic/fst_tick_gen.v
// One microsecond tick generator for the trigger controller.
// Assumes ref_clk period divides one microsecond evenly.
`timescale 1ns/1ns
`include "fst_defines.vh"
module fst_tick_gen
#(
  parameter DIV = `FST_TICK_CYCLES
)
(
  input  wire ref_clk,
  input  wire sys_rst,
  output reg  tickOut
);
  reg [7:0] divCnt_q;

  // Free running divider; the tick is one clock wide every microsecond.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      divCnt_q <= 8'h00;
      tickOut  <= 1'b0;
    end
    else if (divCnt_q == DIV[7:0] - 8'h01)
    begin
      divCnt_q <= 8'h00;
      tickOut  <= 1'b1;
    end
    else
    begin
      divCnt_q <= divCnt_q + 8'h01;
      tickOut  <= 1'b0;
    end
  end
endmodule // fst_tick_gen

//--- logic/fst_trigger_ctrl.v
// Frame start trigger, start delay and exposure control.
// Assumes trigger inputs are asynchronous pins and settings are static
// while an exposure is in progress.
`timescale 1ns/1ns
`include "fst_defines.vh"
module fst_trigger_ctrl
#(
  parameter TW = `FST_TIME_W,
  parameter DW = `FST_DELAY_W
)
(
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          extLine1,
  input  wire          extCc1,
  input  wire          extCc2,
  input  wire          extCc3,
  input  wire          trigEnable,
  input  wire [2:0]    trigSource,
  input  wire          edgeFalling,
  input  wire          exposeMode,
  input  wire [TW-1:0] exposeRaw,
  input  wire [TW-1:0] overlapRaw,
  input  wire [DW-1:0] delayRaw,
  input  wire          overErrClr,
  output reg           waitTrigger,
  output reg           exposeActive,
  output reg           frameStart,
  output reg           overErr
);
  localparam S_IDLE  = 4'b0001;
  localparam S_DELAY = 4'b0010;
  localparam S_EXPO  = 4'b0100;
  localparam S_DONE  = 4'b1000;

  reg  [3:0]    sync1_q;
  reg  [3:0]    sync2_q;
  reg           ext_frame_start_in_q;
  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg  [TW-1:0] cnt_q;
  reg  [TW-1:0] cnt_d;
  reg  [TW-1:0] expoCnt_q;
  wire          tick;
  wire          hwSel;
  wire          selLevel;
  wire          actEdge;
  wire          endEdge;
  wire [DW-1:0] delayLen;

  // Saturate the delay so a larger setting never stretches past one second.
  function [DW-1:0] clampDelay;
    input [DW-1:0] v;
    begin
      clampDelay = (v > `FST_DELAY_MAX) ? `FST_DELAY_MAX : v;
    end
  endfunction

  // One step up for the tick counters, shared by delay and exposure timing.
  function [TW-1:0] bump;
    input [TW-1:0] v;
    begin
      bump = v + {{(TW-1){1'b0}}, 1'b1};
    end
  endfunction

  fst_tick_gen u_tick
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tickOut (tick)
  );

  // Two stage synchronisers; only the second stage feeds edge detection.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {extCc3, extCc2, extCc1, extLine1};
      sync2_q <= sync1_q;
    end
  end

  // Software source selects no pin, so hardware logic stays quiet then.
  assign hwSel = trigEnable && (trigSource <= `FST_SRC_CC3);
  assign selLevel = sync2_q[trigSource[1:0]];

  // Previous level of the selected trigger for edge detection.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      ext_frame_start_in_q <= 1'b0;
    else
      ext_frame_start_in_q <= selLevel;
  end

  // Active edge per edge setting; the opposite edge ends width exposure.
  assign actEdge = hwSel && ((edgeFalling == `FST_EDGE_FALLING) ?
    (ext_frame_start_in_q & ~selLevel) :
    (~ext_frame_start_in_q & selLevel));
  assign endEdge = hwSel && ((edgeFalling == `FST_EDGE_FALLING) ?
    (~ext_frame_start_in_q & selLevel) :
    (ext_frame_start_in_q & ~selLevel));
  assign delayLen = clampDelay(delayRaw);

  // Next state; edges outside the idle state start nothing.
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE:
      begin
        cnt_d = {TW{1'b0}};
        if (actEdge)
        begin
          if (delayLen == {DW{1'b0}})
            state_d = S_EXPO;
          else
            state_d = S_DELAY;
        end
      end
      S_DELAY:
      begin
        if (tick)
          cnt_d = bump(cnt_q);
        if (tick && bump(cnt_q) >= {{(TW-DW){1'b0}}, delayLen})
        begin
          state_d = S_EXPO;
          cnt_d   = {TW{1'b0}};
        end
      end
      S_EXPO:
      begin
        // Only two exposure modes exist, chosen by one bit.
        if (exposeMode == `FST_MODE_WIDTH)
        begin
          if (endEdge || !hwSel)
            state_d = S_DONE;
        end
        else if (tick)
        begin
          cnt_d = bump(cnt_q);
          if (cnt_d >= exposeRaw)
            state_d = S_DONE;
        end
      end
      S_DONE:
        state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  // State, counters and outputs; one frame start pulse per accepted edge.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q      <= S_IDLE;
      cnt_q        <= {TW{1'b0}};
      expoCnt_q    <= {TW{1'b0}};
      frameStart   <= 1'b0;
      exposeActive <= 1'b0;
      overErr      <= 1'b0;
      waitTrigger  <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      frameStart   <= (state_q != S_EXPO) && (state_d == S_EXPO);
      exposeActive <= (state_d == S_EXPO);
      if (state_q != S_EXPO)
        expoCnt_q <= {TW{1'b0}};
      else if (tick && expoCnt_q != {TW{1'b1}})
        expoCnt_q <= bump(expoCnt_q);
      // Set beats clear when both land in the same cycle.
      if (actEdge && state_q != S_IDLE)
        overErr <= 1'b1;
      else if (overErrClr)
        overErr <= 1'b0;
      // In width mode the status may return once the overlap time passes,
      // since the ending edge is then the only thing still awaited.
      // The status stays low in the start cycle even with a zero limit.
      waitTrigger <= (state_d == S_IDLE) ||
        ((state_q == S_EXPO) && (state_d == S_EXPO) &&
         (exposeMode == `FST_MODE_WIDTH) &&
         (expoCnt_q >= overlapRaw));
    end
  end
endmodule // fst_trigger_ctrl

//--- test/fst_trigger_ctrl_checker.sv
// Port checks for the frame start trigger controller.
// Assumes one clock domain and the tick length of fst_defines.vh.
`timescale 1ns/1ns
`include "fst_defines.vh"
module fst_trigger_ctrl_checker
#(
  parameter TW = 22,
  parameter DW = 20
)
(
  input wire          ref_clk,
  input wire          sys_rst,
  input wire          extLine1,
  input wire          trigEnable,
  input wire [2:0]    trigSource,
  input wire          edgeFalling,
  input wire          exposeMode,
  input wire [TW-1:0] exposeRaw,
  input wire [DW-1:0] delayRaw,
  input wire          overErrClr,
  input wire          waitTrigger,
  input wire          exposeActive,
  input wire          frameStart,
  input wire          overErr
);
  localparam int TK = `FST_TICK_CYCLES;
  int  cnt;
  wire busy = !waitTrigger || exposeActive;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Counts exposure cycles, since the first tick may be partial.
  always @(posedge ref_clk) cnt <= frameStart ? 1 : cnt + exposeActive;
  sequence s_back;
    ##[1:2] waitTrigger;
  endsequence
  chk_start_exit: assert property (frameStart |-> exposeActive && !waitTrigger)
    else $error("start kept waiting status");
  chk_one_pulse: assert property (frameStart |=> !frameStart)
    else $error("start pulse too long");
  chk_wait_back: assert property ($fell(exposeActive) |-> s_back)
    else $error("waiting status did not return");
  chk_timed_len: assert property ($fell(exposeActive) && !exposeMode |->
    cnt <= TK * (exposeRaw + (exposeRaw == 0)) + 1 && cnt + TK >= TK * exposeRaw)
    else $error("timed exposure length wrong");
  chk_err_sticky: assert property (overErr && !overErrClr |=> overErr)
    else $error("overtrigger flag lost");
  chk_err_cause: assert property ($rose(overErr) |-> $past(busy))
    else $error("overtrigger while idle");
  chk_zero_delay: assert property (trigEnable && trigSource == 3'h0
    && !edgeFalling && delayRaw == 0 && waitTrigger && !exposeActive
    && $rose(extLine1) |-> ##[1:5] frameStart)
    else $error("edge did not start exposure");
  chk_width_end: assert property (exposeMode && delayRaw == 0 && exposeActive
    && trigSource == 3'h0 && $changed(extLine1) && extLine1 == edgeFalling
    |-> ##[1:5] !exposeActive)
    else $error("width exposure did not end");
endmodule // fst_trigger_ctrl_checker
bind fst_trigger_ctrl fst_trigger_ctrl_checker #(.TW(TW), .DW(DW)) chk_i
  (.ref_clk, .sys_rst, .extLine1, .trigEnable, .trigSource, .edgeFalling,
   .exposeMode, .exposeRaw, .delayRaw, .overErrClr, .waitTrigger,
   .exposeActive, .frameStart, .overErr);

//--- test/fst_trig_src.sv
// External trigger source model driving the four trigger lines.
// Assumes the bench calls pulse and sets the idle level by edge choice.
`timescale 1ns/1ns
module fst_trig_src
(
  input  wire logic       ref_clk,
  input  wire logic       fall,
  output logic [3:0]      pins
);
  logic [3:0] act = 4'h0;
  // Lines rest at the level opposite to the active edge.
  assign pins = act ^ {4{fall}}; // Line 1 serves only as an input.
  // Drives one line active for hi cycles, changing on falling edges.
  task pulse(input int n, input int hi);
    @(negedge ref_clk) act[n] = 1'b1;
    repeat (hi) @(negedge ref_clk);
    act[n] = 1'b0;
  endtask
endmodule // fst_trig_src

//--- test/tb.sv
// Self-checking bench for the frame start trigger controller.
// Assumes the bound checker and the trigger source model.
`timescale 1ns/1ns
module tb;
  logic ref_clk = 0, sys_rst = 1, trigEnable = 1, edgeFalling = 0;
  logic exposeMode = 0, overErrClr = 0;
  logic [2:0] trigSource = 3'h0;
  // Overlap limit sits below the shortest width exposure used here.
  logic [21:0] exposeRaw = 22'h2, overlapRaw = 22'h1;
  logic [19:0] delayRaw = 20'h0;
  logic [3:0] pins;
  wire waitTrigger, exposeActive, frameStart, overErr;
  int failures = 0, samples_checked = 0, frames = 0, k;
  fst_trig_src src (.ref_clk, .fall(edgeFalling), .pins);
  fst_trigger_ctrl dut (.ref_clk, .sys_rst, .extLine1(pins[0]),
    .extCc1(pins[1]), .extCc2(pins[2]), .extCc3(pins[3]), .trigEnable,
    .trigSource, .edgeFalling, .exposeMode, .exposeRaw, .overlapRaw,
    .delayRaw, .overErrClr, .waitTrigger, .exposeActive, .frameStart,
    .overErr);
  // Free-running clock; exposures are counted by their start pulse.
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) frames <= frames + (frameStart === 1'b1);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("failures %0d checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for the waiting status, then a short gap.
  task automatic wait_idle;
    for (k = 0; waitTrigger !== 1'b1 && k < 3000; k++) @(negedge ref_clk);
    chk(waitTrigger, 1);
    repeat (5) @(negedge ref_clk); // Gap keeps the rate legal.
  endtask
  // Watchdog sized well beyond the whole sequence.
  initial
  begin
    #2000000 failures++;
    close_out;
  end
  initial
  begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 0;
    @(negedge ref_clk);
    chk(waitTrigger, 1);
    // Each line in turn, a second edge landing inside the exposure.
    for (int s = 0; s < 4; s++)
    begin
      trigSource = s[2:0];
      src.pulse(s, 6);
      chk(waitTrigger, 0);
      src.pulse(s, 6);
      chk(overErr, 1);
      wait_idle;
      chk(frames, s + 1);
      overErrClr = 1;
      @(negedge ref_clk) overErrClr = 0;
      chk(overErr, 0);
    end
    // Falling edge with trigger width runs past the timed length.
    edgeFalling = 1;
    exposeMode = 1;
    trigSource = 3'h0;
    wait_idle;
    src.pulse(0, 100);
    chk(exposeActive, 1);
    chk(waitTrigger, 1);
    repeat (8) @(negedge ref_clk);
    chk(exposeActive, 0);
    // Rising edge with trigger width, ended by the falling edge.
    edgeFalling = 0;
    wait_idle;
    src.pulse(0, 100);
    chk(exposeActive, 1);
    repeat (8) @(negedge ref_clk);
    chk(exposeActive, 0);
    exposeMode = 0;
    delayRaw = 20'h4;
    wait_idle;
    src.pulse(0, 2);
    for (k = 2; frames == 6 && k < 400; k++) @(negedge ref_clk);
    chk(k > 70 && k < 135, 1);
    delayRaw = 20'h0;
    wait_idle;
    trigSource = 3'h4;
    src.pulse(0, 6);
    wait_idle;
    trigSource = 3'h0;
    trigEnable = 0;
    src.pulse(0, 6);
    wait_idle;
    chk(frames, 7);
    close_out;
  end
endmodule // tb
